/* dv/pwc_wave_counter_sva.sv */
// Checker of bus timing, counter steps and interrupt level
module pwc_wave_counter_sva (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    // Counter and events
    input wire logic        pwm_tick,
    input wire logic        loops_completed_event,
    input wire logic [14:0] wave_count,
    input wire logic        count_direction_select,
    input wire logic        module_on,
    input wire logic        period_end,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_down;
        module_on && pwm_tick && count_direction_select && wave_count != 15'h0 ##1 module_on;
    endsequence
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_one_wait: assert property (s_req |=> !avs_waitrequest)
        else $error("wait too long");
    a_resp_okay: assert property (avs_response == 2'h0)
        else $error("bad response");
    a_read_stands: assert property (!($past(avs_read) && $past(avs_waitrequest))
        |-> $stable(avs_readdata)) else $error("read data moved");
    a_off_clear: assert property (!module_on && !$past(module_on) |-> wave_count == 15'h0)
        else $error("count kept while off");
    a_hold_idle: assert property (module_on && $past(module_on) && !$past(pwm_tick)
        |-> $stable(wave_count)) else $error("count moved without tick");
    a_down_step: assert property (s_down |-> wave_count == $past(wave_count) - 15'h1)
        else $error("bad down step");
    a_period_one: assert property (period_end |=> !period_end)
        else $error("period pulse too long");
    a_period_on: assert property (period_end |-> $past(module_on))
        else $error("period end while off");
    a_irq_rise: assert property ($rose(irq) |-> $past(loops_completed_event)
        || $past(period_end) || $past(avs_write)) else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
        else $error("irq fell without write");
endmodule : pwc_wave_counter_sva
////////////////////////////////////////////////////////////////////////////////
bind pwc_wave_counter pwc_wave_counter_sva u_sva (.*);

/* dv/test_pwc_wave_counter.sv */
// Bench of register access, counting and interrupt
module test_pwc_wave_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] avs_address = 12'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, count_direction_select, module_on, period_end, irq;
    logic [1:0] avs_response;
    logic pwm_tick = 1'b0;
    logic loops_completed_event = 1'b0;
    pwc_pkg::pwc_half_t fetch_half = '0;
    pwc_pkg::pwc_cmp_t wave_cmp;
    logic [14:0] wave_count;
    logic [14:0] up_seq [7] = '{15'h1, 15'h2, 15'h3, 15'h4, 15'h5, 15'h0, 15'h1};
    logic [14:0] ud_seq [7] = '{15'h1, 15'h2, 15'h3, 15'h2, 15'h1, 15'h0, 15'h1};
    logic [14:0] wf_seq [5] = '{15'h1, 15'h2, 15'h3, 15'h4, 15'h0};
    logic [15:0] wf_val [4] = '{16'h11, 16'h22, 16'h33, 16'h4};
    int mismatches = 0;
    int n_compared = 0;
    always #5 core_clk = ~core_clk;
    pwc_wave_counter dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .pwm_tick(pwm_tick),
        .loops_completed_event(loops_completed_event), .fetch_half(fetch_half),
        .wave_cmp(wave_cmp), .wave_count(wave_count),
        .count_direction_select(count_direction_select), .module_on(module_on),
        .period_end(period_end), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            mismatches++;
            stop_test();
        end
    endtask : bus
    task rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task tk(input logic [14:0] e);
        @(posedge core_clk) pwm_tick <= 1'b1;
        @(posedge core_clk) pwm_tick <= 1'b0;
        #1 chk(32'(wave_count), 32'(e));
    endtask : tk
    task ev;
        @(posedge core_clk) loops_completed_event <= 1'b1;
        @(posedge core_clk) loops_completed_event <= 1'b0;
    endtask : ev
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(12'h500, 32'h0);
        rd(12'h504, 32'h0);
        rd(12'h508, 32'h3ff);
        rd(12'h548, 32'h0);
        rd(12'h600, 32'h0);
        bus(1'b1, 12'h508, 32'h2);
        rd(12'h508, 32'h3);
        bus(1'b1, 12'h508, 32'h5);
        bus(1'b1, 12'h500, 32'h1);
        foreach (up_seq[k]) tk(up_seq[k]);
        bus(1'b1, 12'h500, 32'h0);
        bus(1'b1, 12'h504, 32'h1);
        chk(32'(wave_count), 32'h0);
        bus(1'b1, 12'h508, 32'h3);
        bus(1'b1, 12'h500, 32'h1);
        foreach (ud_seq[k]) tk(ud_seq[k]);
        rd(12'h540, 32'h2);
        bus(1'b1, 12'h54c, 32'h3);
        ev();
        #1 chk(32'(irq), 32'h0);
        bus(1'b1, 12'h544, 32'h1);
        #1 chk(32'(irq), 32'h1);
        rd(12'h540, 32'h1);
        rd(12'h548, 32'h1);
        bus(1'b1, 12'h548, 32'h1);
        #1 chk(32'(irq), 32'h0);
        rd(12'h548, 32'h0);
        bus(1'b1, 12'h544, 32'h1);
        bus(1'b1, 12'h54c, 32'h1);
        #1 chk(32'(irq), 32'h0);
        bus(1'b1, 12'h500, 32'h0);
        bus(1'b1, 12'h504, 32'h0);
        bus(1'b1, 12'h508, 32'h9);
        bus(1'b1, 12'h510, 32'h3);
        foreach (wf_val[k]) begin
            @(posedge core_clk) fetch_half <= '{1'b1, 2'(k), wf_val[k]};
            @(posedge core_clk) fetch_half.valid <= 1'b0;
        end
        #1 chk({wave_cmp.ch0, wave_cmp.ch1}, 32'h00110022);
        chk(32'(wave_cmp.ch2), 32'h33);
        bus(1'b1, 12'h500, 32'h1);
        foreach (wf_seq[k]) tk(wf_seq[k]);
        stop_test();
    end
endmodule : test_pwc_wave_counter

/* rtl/pwc_pkg.sv */
// Package of offsets, fields, reset values and types for the wave counter configuration
package pwc_pkg;

    localparam logic [11:0] OFF_MODULE_ON      = 12'h500;
    localparam logic [11:0] OFF_COUNTING_STYLE = 12'h504;
    localparam logic [11:0] OFF_PERIOD_TOP     = 12'h508;
    localparam logic [11:0] OFF_DECODER_LOAD   = 12'h510;
    localparam logic [11:0] OFF_INT_STATUS     = 12'h540;
    localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h544;
    localparam logic [11:0] OFF_INT_ENABLE_CLR = 12'h548;
    localparam logic [11:0] OFF_INT_STATUS_CLR = 12'h54c;

    localparam int          TOP_W              = 15;
    localparam int          LOAD_W             = 2;
    localparam int          INT_LOOPS_BIT      = 0;
    localparam int          INT_PERIOD_BIT     = 1;
    localparam int          INT_W              = 2;

    localparam logic        RST_MODULE_ON      = 1'b0;
    localparam logic        RST_COUNTING_STYLE = 1'b0;
    localparam logic [14:0] RST_PERIOD_TOP     = 15'h03ff;
    localparam logic [14:0] TOP_MIN            = 15'h0003;
    localparam logic [1:0]  RST_LOAD           = 2'h0;
    localparam logic [1:0]  LOAD_A             = 2'h3;
    localparam logic [1:0]  RST_INT_EN         = 2'h0;

    typedef enum logic [1:0] {
        PWC_LOAD_COMMON     = 2'b00,
        PWC_LOAD_GROUPED    = 2'b01,
        PWC_LOAD_INDIVIDUAL = 2'b10,
        PWC_LOAD_WAVE       = 2'b11
    } pwc_load_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  index;
        logic [15:0] data;
    } pwc_half_t;

    typedef struct packed {
        logic [15:0] ch0;
        logic [15:0] ch1;
        logic [15:0] ch2;
    } pwc_cmp_t;

endpackage : pwc_pkg

/* rtl/pwc_wave_counter.sv */
// Wave counter configuration, counter and register slave
//
// Operation
// RULE1: Write one disables loops interrupt; reads state.
// RULE2: Module-on bit enables generator; resets off.
// RULE3: Style bit: up-only or up/down counting.
// RULE4: Counter top from register, 3..32767, 0x3ff.
// RULE5: Load_a load ignores the register top.
// RULE6: Load_a: three half-words channels, fourth top.
// RULE7: Up wraps to zero; up/down reverses ends.
//
// Register access over Avalon-MM is this design's own decision.
module pwc_wave_counter (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // Avalon-MM slave
    input  wire logic [11:0]            avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    output logic      [1:0]             avs_response,
    // Prescaled count enable and events
    input  wire logic                   pwm_tick,
    input  wire logic                   loops_completed_event,
    // Fetched half-words from the sequence reader
    input  wire pwc_pkg::pwc_half_t     fetch_half,
    // Counter and configuration outputs
    output pwc_pkg::pwc_cmp_t           wave_cmp,
    output logic      [14:0]            wave_count,
    output logic                        count_direction_select,
    output logic                        module_on,
    output logic                        period_end,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode
    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } pwc_bus_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } pwc_dir_t;

    logic                               counting_style;
    logic      [14:0]                   period_top_value;
    pwc_pkg::pwc_load_t                 decoder_load;
    logic      [14:0]                   ram_top;
    logic      [1:0]                    int_status;
    logic      [1:0]                    int_enable;
    logic                               ack;
    logic      [31:0]                   next_readdata;
    logic      [1:0]                    int_events;
    logic      [14:0]                   next_count;
    pwc_dir_t                           next_dir;
    pwc_dir_t                           dir_state;
    pwc_bus_t                           bus_state;
    pwc_bus_t                           next_bus_state;

    wire        req        = (avs_read | avs_write) & ~ack;
    wire        take       = (avs_read | avs_write) & ack;
    wire        wr         = avs_write & take & avs_byteenable[0];
    wire        wr_hi      = avs_write & take & avs_byteenable[1];
    wire        sel_on     = avs_address == pwc_pkg::OFF_MODULE_ON;
    wire        sel_style  = avs_address == pwc_pkg::OFF_COUNTING_STYLE;
    wire        sel_top    = avs_address == pwc_pkg::OFF_PERIOD_TOP;
    wire        sel_load   = avs_address == pwc_pkg::OFF_DECODER_LOAD;
    wire        sel_stat   = avs_address == pwc_pkg::OFF_INT_STATUS;
    wire        sel_ienset = avs_address == pwc_pkg::OFF_INT_ENABLE_SET;
    wire        sel_ienclr = avs_address == pwc_pkg::OFF_INT_ENABLE_CLR;
    wire        sel_sclr   = avs_address == pwc_pkg::OFF_INT_STATUS_CLR;
    wire        mapped     = sel_on | sel_style | sel_top | sel_load | sel_stat
                           | sel_ienset | sel_ienclr | sel_sclr;
    wire [14:0] wr_top     = {avs_writedata[14:8], avs_writedata[7:0]};
    wire [14:0] top_clip   = (wr_top < pwc_pkg::TOP_MIN) ? pwc_pkg::TOP_MIN : wr_top;
    wire        wave_load  = decoder_load == pwc_pkg::PWC_LOAD_WAVE;
    // RULE5: top source select
    wire [14:0] active_top = wave_load ? ram_top : period_top_value;
    wire [1:0]  wr_bits    = avs_writedata[1:0];
    wire [31:0] rd_word    = mapped ? next_readdata : 32'h0000_0000;

    assign avs_waitrequest = req;
    assign ack             = bus_state == BUS_ANSWER;
    assign avs_response    = 2'h0;
    assign irq             = |(int_status & int_enable);
    assign int_events      = {period_end, loops_completed_event};

    ////////////////////////////////////////////////////////////////////////////
    // Readback selection
    wire [31:0] rd_on      = {31'h0000_0000, module_on};
    wire [31:0] rd_style   = {31'h0000_0000, counting_style};
    wire [31:0] rd_top     = {17'h0_0000, period_top_value};
    wire [31:0] rd_load    = {30'h0000_0000, decoder_load};
    wire [31:0] rd_stat    = {30'h0000_0000, int_status};
    // RULE1: enable state readback
    wire [31:0] rd_ien     = {30'h0000_0000, int_enable};

    assign next_readdata = sel_on                    ? rd_on
                         : sel_style                 ? rd_style
                         : sel_top                   ? rd_top
                         : sel_load                  ? rd_load
                         : sel_stat                  ? rd_stat
                         : (sel_ienset | sel_ienclr) ? rd_ien
                         : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake, one wait cycle then acknowledge
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            BUS_IDLE: begin
                if (avs_read | avs_write) begin
                    next_bus_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state    <= BUS_IDLE;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            if (req & avs_read) begin
                avs_readdata <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            module_on <= pwc_pkg::RST_MODULE_ON;
        end else if (wr & sel_on) begin
            // RULE2: module on control
            module_on <= avs_writedata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            counting_style <= pwc_pkg::RST_COUNTING_STYLE;
        end else if (wr & sel_style) begin
            // RULE3: counting style store
            counting_style <= avs_writedata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            decoder_load <= pwc_pkg::pwc_load_t'(pwc_pkg::RST_LOAD);
        end else if (wr & sel_load) begin
            decoder_load <= pwc_pkg::pwc_load_t'(avs_writedata[1:0]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_top_value <= pwc_pkg::RST_PERIOD_TOP;
        end else if (wr & wr_hi & sel_top) begin
            // RULE4: top value clipped to range
            period_top_value <= top_clip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enable and sticky status
    generate
        for (genvar b = 0; b < pwc_pkg::INT_W; b++) begin : g_int
            wire ien_set = wr & sel_ienset & wr_bits[b];
            wire ien_clr = wr & sel_ienclr & wr_bits[b];
            wire st_clr  = wr & sel_sclr & wr_bits[b];

            // RULE1: write one disables
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    int_enable[b] <= pwc_pkg::RST_INT_EN[b];
                end else if (ien_set) begin
                    int_enable[b] <= 1'b1;
                end else if (ien_clr) begin
                    int_enable[b] <= 1'b0;
                end
            end

            // Event set wins over clear
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    int_status[b] <= 1'b0;
                end else if (int_events[b]) begin
                    int_status[b] <= 1'b1;
                end else if (st_clr) begin
                    int_status[b] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Load_a load spreading
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_cmp <= '0;
            ram_top  <= pwc_pkg::RST_PERIOD_TOP;
        end else if (fetch_half.valid & wave_load) begin
            // RULE6: half-words to channels and top
            unique case (fetch_half.index)
                2'h0: begin
                    wave_cmp.ch0 <= fetch_half.data;
                end
                2'h1: begin
                    wave_cmp.ch1 <= fetch_half.data;
                end
                2'h2: begin
                    wave_cmp.ch2 <= fetch_half.data;
                end
                2'h3: begin
                    ram_top <= (fetch_half.data[14:0] < pwc_pkg::TOP_MIN)
                             ? pwc_pkg::TOP_MIN : fetch_half.data[14:0];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wave counter
    wire        at_top     = wave_count >= active_top;
    wire        at_zero    = wave_count == 15'h0000;
    wire [14:0] count_up   = wave_count + 15'h0001;
    wire [14:0] count_down = wave_count - 15'h0001;
    wire [14:0] top_less   = active_top - 15'h0001;
    wire        step       = module_on & pwm_tick;
    wire        at_end     = counting_style ? (count_direction_select & wave_count == 15'h0001)
                                            : at_top;

    assign count_direction_select = dir_state == DIR_DOWN;

    always_comb begin
        next_count = wave_count;
        next_dir   = dir_state;
        unique case (dir_state)
            DIR_UP: begin
                if (!counting_style) begin
                    // RULE7: wrap at top
                    next_count = at_top ? 15'h0000 : count_up;
                end else if (at_top) begin
                    // RULE7: reverse at top
                    next_dir   = DIR_DOWN;
                    next_count = top_less;
                end else begin
                    next_count = count_up;
                end
            end
            DIR_DOWN: begin
                if (!counting_style) begin
                    next_dir   = DIR_UP;
                    next_count = at_top ? 15'h0000 : count_up;
                end else if (at_zero) begin
                    // RULE7: reverse at zero
                    next_dir   = DIR_UP;
                    next_count = 15'h0001;
                end else begin
                    next_count = count_down;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_count <= 15'h0000;
            dir_state  <= DIR_UP;
        end else if (!module_on) begin
            // RULE2: off holds counter idle
            wave_count <= 15'h0000;
            dir_state  <= DIR_UP;
        end else if (pwm_tick) begin
            // RULE3: up or up/down step
            wave_count <= next_count;
            dir_state  <= next_dir;
        end
    end

    // Period end pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_end <= 1'b0;
        end else begin
            period_end <= step & at_end;
        end
    end

endmodule : pwc_wave_counter
